// ==== rtl/flash_selfprog_pkg.sv ====
// package: register addresses, field positions, codes and timing for the self-programming controller
package flash_selfprog_pkg;

  // ==========================================================
  // register addresses (8-bit space)
  localparam logic [7:0] ADDR_FLASH_CMD     = 8'hA3;
  localparam logic [7:0] ADDR_PTR_HIGH      = 8'hA4;
  localparam logic [7:0] ADDR_PTR_LOW       = 8'hA5;
  localparam logic [7:0] ADDR_CMP_HIGH      = 8'hA6;
  localparam logic [7:0] ADDR_CMP_LOW       = 8'hA7;
  localparam logic [7:0] ADDR_WRITE_BUF     = 8'hA8;
  localparam logic [7:0] ADDR_STATUS        = 8'hA9;
  localparam logic [7:0] ADDR_PROTECT_CMD   = 8'hAA;
  localparam logic [7:0] ADDR_MODE_CTRL     = 8'hAB;

  // ==========================================================
  // values and field positions
  localparam logic [7:0] PROTECT_KEY        = 8'hA5;
  localparam logic [7:0] MODE_SELF          = 8'h01;
  localparam logic [7:0] MODE_NORMAL        = 8'h00;
  localparam int         STAT_SEQ_BIT       = 0;
  localparam int         STAT_VERIFY_BIT    = 1;
  localparam int         STAT_PROTECT_BIT   = 2;
  localparam logic [7:0] RESET_ZERO         = 8'h00;
  localparam logic [2:0] CMD_VERIFY_BLOCK   = 3'h1;
  localparam logic [2:0] CMD_VERIFY_RANGE   = 3'h2;
  localparam logic [2:0] CMD_BLOCK_ERASE    = 3'h3;
  localparam logic [2:0] CMD_BLANK_CHECK    = 3'h4;
  localparam logic [2:0] CMD_BYTE_WRITE     = 3'h5;

  // ==========================================================
  // timing: fixed per-step time of the internal sequencer
  localparam int CLK_MHZ        = 200;
  localparam int STEP_TIME_NS   = 100;
  localparam int STEP_CYCLES    = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_KEYED = 3'b001,
    SEQ_VAL   = 3'b010,
    SEQ_INV   = 3'b011
  } seq_state_t;

  typedef enum logic [2:0] {
    OP_IDLE   = 3'b000,
    OP_CHECK  = 3'b001,
    OP_STEP   = 3'b010,
    OP_DONE   = 3'b011
  } op_state_t;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } cpu_wr_t;

  typedef struct packed {
    logic       busy;
    logic       last;
    logic       fail;
  } step_resp_t;

endpackage

// ==== rtl/flash_step_timer.sv ====
// one flash step: a fixed-length wait, then a done pulse with the cell's pass/fail answer
`timescale 1ns/1ps
`default_nettype none
module flash_step_timer
  import flash_selfprog_pkg::*;
#(
  parameter int CYCLES = STEP_CYCLES
) (
  input  wire logic clk_sys,   // system clock
  input  wire logic reset,     // synchronous reset
  input  wire logic start,     // begin one step
  input  wire logic cellFail,  // cell result sampled at the end
  output logic      done,      // one-cycle done pulse
  output logic      fail       // result, valid with done
);

  typedef struct packed {
    logic        run;
    logic [15:0] cnt;
    logic        done;
    logic        fail;
  } timer_st_t;

  timer_st_t st_ff;
  timer_st_t nxt_st;

  // ==========================================================
  // count down one step
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (start && !st_ff.run) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = 16'(CYCLES - 1);
    end else if (st_ff.run) begin
      if (st_ff.cnt == 16'h0000) begin
        nxt_st.run  = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.fail = cellFail;
      end else begin
        nxt_st.cnt = st_ff.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign fail = st_ff.fail;

endmodule
`default_nettype wire

// ==== rtl/flash_self_program_mode_ctrl.sv ====
// top: protected mode switching, command registers and HALT-started flash command sequencer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: entry needs key A5H, then 01H, FEH, 01H to mode control; last write switches.
// R2: value write and inverse write of the sequence never change the mode.
// R3: exit needs key A5H, then 00H, FFH, 00H; the last write takes effect.
// R4: status bit 0 flags a failed protected sequence; software clears and retries.
// R5: software clears the command register to 00H before a mode sequence.
// R6: software clears status before each mode sequence and each command.
// R7: after entry software runs NOP then HALT before reading bit 0.
// R8: software masks interrupts before entry and restores them after exit.
// R9: CPU clock must be at least 1 MHz during self-programming.
// R10: mode and command routines run from flash not being erased or written.
// R11: command code 03H erases the block given by the high address pointer.
// R12: for erase, software sets high compare equal high pointer, low pair 00H.
// R13: a set command starts on HALT; CPU resumes after HALT when done.
// R14: status bit 1 verify or command error, bit 2 protection error; zero means ok.
// R15: software retries a failed erase up to its limit, then declares failure.
// R16: software checks the protection flag separately for forbidden blocks.
// R17: software kicks the watchdog with ACH before each command.
// R18: codes 01H,02H verify, 04H blank check, 05H byte write; others prohibited.
// R19: undefined code aborts at once, setting verify and protection flags.
// R20: protection flag set for protected block or unerased-bit write; cleared by zero or reset.
// R21: software clears bits 5 to 7 of high pointer and high compare.
// R22: a broken protected order aborts, keeps the mode, sets the sequence flag.
module flash_self_program_mode_ctrl
  import flash_selfprog_pkg::*;
(
  input  wire logic       clk_sys,      // system clock
  input  wire logic       reset,        // synchronous reset, active high
  input  wire cpu_wr_t    cpuWr,        // cpu register write
  input  wire logic [7:0] rdAddr,       // cpu read address
  input  wire logic       haltExec,     // pulse: cpu executed HALT
  input  wire logic [4:0] protectLimit, // blocks below this are protected
  input  wire logic       cellFail,     // flash array reports failing step
  output logic [7:0]      rdData,       // registered read data
  output logic            selfProgMode, // 1 while in self-programming mode
  output logic            cpuHold,      // cpu stays in HALT while set
  output logic [7:0]      flashAddrHi,  // array address high
  output logic [7:0]      flashAddrLo,  // array address low
  output logic [7:0]      flashWrData,  // array write data
  output logic [2:0]      flashOp,      // active command code, 0 when idle
  output logic            flashStep     // pulse: one array step issued
);

  typedef struct packed {
    seq_state_t seq;
    op_state_t  op;
    logic       mode;
    logic [7:0] cmd;
    logic [7:0] ptrHi;
    logic [7:0] ptrLo;
    logic [7:0] cmpHi;
    logic [7:0] cmpLo;
    logic [7:0] wbuf;
    logic [2:0] status;
    logic       hold;
    logic       step;
    logic [7:0] rd;
    logic [7:0] seqVal;
    logic [2:0] opCode;
  } ctrl_st_t;

  ctrl_st_t st_ff;
  ctrl_st_t nxt_st;
  logic     stepDone;
  logic     stepFail;
  logic     isMode;
  logic     blockProt;

  // ==========================================================
  // array step timing
  flash_step_timer #(
    .CYCLES (STEP_CYCLES)
  ) u_step (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (st_ff.step),
    .cellFail (cellFail),
    .done     (stepDone),
    .fail     (stepFail)
  );

  assign isMode    = cpuWr.wrEn && (cpuWr.addr == ADDR_MODE_CTRL);
  assign blockProt = (st_ff.ptrHi[4:0] < protectLimit);

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.step = 1'b0;

    // plain register writes
    if (cpuWr.wrEn) begin
      case (cpuWr.addr)
        ADDR_FLASH_CMD:  nxt_st.cmd   = {5'h00, cpuWr.data[2:0]};
        ADDR_PTR_HIGH:   nxt_st.ptrHi = cpuWr.data;
        ADDR_PTR_LOW:    nxt_st.ptrLo = cpuWr.data;
        ADDR_CMP_HIGH:   nxt_st.cmpHi = cpuWr.data;
        ADDR_CMP_LOW:    nxt_st.cmpLo = cpuWr.data;
        ADDR_WRITE_BUF:  nxt_st.wbuf  = cpuWr.data;
        ADDR_STATUS:     nxt_st.status = cpuWr.data[2:0]; // R20
        default:         nxt_st.cmd   = st_ff.cmd;
      endcase
    end

    // protected sequence
    case (st_ff.seq)
      SEQ_IDLE: begin
        if (cpuWr.wrEn && cpuWr.addr == ADDR_PROTECT_CMD && cpuWr.data == PROTECT_KEY) begin
          nxt_st.seq = SEQ_KEYED;
        end else if (isMode) begin
          nxt_st.status[STAT_SEQ_BIT] = 1'b1; // R22
        end
      end
      SEQ_KEYED: begin
        if (isMode && (cpuWr.data == MODE_SELF || cpuWr.data == MODE_NORMAL)) begin
          nxt_st.seq = SEQ_VAL; // R2
          nxt_st.seqVal = cpuWr.data; // kept apart from read data for the later steps
        end else if (cpuWr.wrEn) begin
          nxt_st.seq = SEQ_IDLE;
          nxt_st.status[STAT_SEQ_BIT] = 1'b1; // R22
        end
      end
      SEQ_VAL: begin
        if (isMode && cpuWr.data == ~st_ff.seqVal) begin
          nxt_st.seq = SEQ_INV; // R2
        end else if (cpuWr.wrEn) begin
          nxt_st.seq = SEQ_IDLE;
          nxt_st.status[STAT_SEQ_BIT] = 1'b1; // R22
        end
      end
      SEQ_INV: begin
        if (isMode && cpuWr.data == st_ff.seqVal) begin
          nxt_st.seq  = SEQ_IDLE;
          nxt_st.mode = (cpuWr.data == MODE_SELF); // R1 R3
        end else if (cpuWr.wrEn) begin
          nxt_st.seq = SEQ_IDLE;
          nxt_st.status[STAT_SEQ_BIT] = 1'b1; // R4 R22
        end
      end
      default: nxt_st.seq = SEQ_IDLE;
    endcase

    // command sequencer
    case (st_ff.op)
      OP_IDLE: begin
        if (haltExec && st_ff.mode && st_ff.cmd[2:0] != 3'h0) begin
          nxt_st.hold   = 1'b1; // R13
          nxt_st.opCode = st_ff.cmd[2:0]; // code of the started command
          nxt_st.op     = OP_CHECK;
        end
      end
      OP_CHECK: begin
        if (st_ff.cmd[2:0] > CMD_BYTE_WRITE) begin
          nxt_st.status[STAT_VERIFY_BIT]  = 1'b1; // R19
          nxt_st.status[STAT_PROTECT_BIT] = 1'b1; // R18 R19
          nxt_st.op = OP_DONE;
        end else if (blockProt) begin
          nxt_st.status[STAT_PROTECT_BIT] = 1'b1; // R20
          nxt_st.op = OP_DONE;
        end else begin
          if (st_ff.cmd[2:0] == CMD_BLOCK_ERASE) begin
            nxt_st.ptrLo = 8'h00; // R11
          end
          nxt_st.step = 1'b1;
          nxt_st.op   = OP_STEP;
        end
      end
      OP_STEP: begin
        if (stepDone) begin
          if (stepFail) begin
            if (st_ff.cmd[2:0] == CMD_BYTE_WRITE) begin
              nxt_st.status[STAT_PROTECT_BIT] = 1'b1; // R20
            end else begin
              nxt_st.status[STAT_VERIFY_BIT] = 1'b1; // R14
            end
            nxt_st.op = OP_DONE;
          end else if (st_ff.cmd[2:0] == CMD_BYTE_WRITE ||
                       st_ff.ptrLo == st_ff.cmpLo ||
                       (st_ff.cmd[2:0] == CMD_BLOCK_ERASE)) begin
            nxt_st.op = OP_DONE; // R11
          end else begin
            nxt_st.ptrLo = st_ff.ptrLo + 8'h01;
            nxt_st.step  = 1'b1;
          end
        end
      end
      OP_DONE: begin
        nxt_st.hold   = 1'b0; // R13
        nxt_st.opCode = 3'h0;
        nxt_st.op   = OP_IDLE;
      end
      default: nxt_st.op = OP_IDLE;
    endcase

    // read path, registered
    case (rdAddr)
      ADDR_FLASH_CMD: nxt_st.rd = st_ff.cmd;
      ADDR_PTR_HIGH:  nxt_st.rd = st_ff.ptrHi;
      ADDR_PTR_LOW:   nxt_st.rd = st_ff.ptrLo;
      ADDR_CMP_HIGH:  nxt_st.rd = st_ff.cmpHi;
      ADDR_CMP_LOW:   nxt_st.rd = st_ff.cmpLo;
      ADDR_WRITE_BUF: nxt_st.rd = st_ff.wbuf;
      ADDR_STATUS:    nxt_st.rd = {5'h00, st_ff.status}; // R14
      ADDR_MODE_CTRL: nxt_st.rd = {7'h00, st_ff.mode};
      default:        nxt_st.rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '{seq: SEQ_IDLE, op: OP_IDLE, ptrHi: RESET_ZERO, ptrLo: RESET_ZERO, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign rdData       = st_ff.rd;
  assign selfProgMode = st_ff.mode;
  assign cpuHold      = st_ff.hold;
  assign flashAddrHi  = st_ff.ptrHi;
  assign flashAddrLo  = st_ff.ptrLo;
  assign flashWrData  = st_ff.wbuf;
  assign flashOp      = st_ff.opCode;
  assign flashStep    = st_ff.step;

endmodule
`default_nettype wire

// ==== testbench/flash_mode_props.sv ====
// checker: mode switching and command sequencing relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module flash_mode_props
  import flash_selfprog_pkg::*;
(
  input wire logic       clk_sys,      // clock
  input wire logic       reset,        // sync reset
  input wire cpu_wr_t    cpuWr,        // cpu write
  input wire logic       haltExec,     // halt pulse
  input wire logic [4:0] protectLimit, // protected below
  input wire logic       selfProgMode, // mode
  input wire logic       cpuHold,      // cpu held
  input wire logic [7:0] flashAddrHi,  // block
  input wire logic [2:0] flashOp,      // active code
  input wire logic       flashStep     // step pulse
);
  // ==========================================================
  // helper: a write to mode control
  logic modeWr;
  assign modeWr = cpuWr.wrEn && cpuWr.addr == ADDR_MODE_CTRL;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // assertions
  a_mode_entry: assert property ($rose(selfProgMode) |-> $past(modeWr && cpuWr.data == MODE_SELF))
    else $error("mode entered without final value write");
  a_mode_exit: assert property ($fell(selfProgMode) && !$past(reset) |-> $past(modeWr && !cpuWr.data[0]))
    else $error("mode left without final value write");
  a_inv_ignored: assert property (modeWr && cpuWr.data[7:1] == 7'h7F |=> $stable(selfProgMode))
    else $error("inverse write changed mode");
  a_halt_start: assert property ($rose(cpuHold) |-> $past(haltExec && selfProgMode))
    else $error("hold without halt in self mode");
  a_halt_normal: assert property (haltExec && !selfProgMode |=> !cpuHold)
    else $error("hold in normal mode");
  a_op_hold: assert property (cpuHold == (flashOp != 3'h0))
    else $error("op code and hold disagree");
  a_undef_abort: assert property ($rose(cpuHold) && flashOp > CMD_BYTE_WRITE |-> !flashStep [*3] ##[0:2] !cpuHold)
    else $error("undefined code not aborted");
  a_erase_len: assert property ($rose(cpuHold) && flashOp == CMD_BLOCK_ERASE |-> ##[2:60] !cpuHold)
    else $error("erase too long");
  a_step_prot: assert property (flashStep |-> cpuHold && flashAddrHi[4:0] >= protectLimit)
    else $error("step on protected block");
  c_entry: cover property ($rose(selfProgMode));
  c_exit: cover property ($fell(selfProgMode));
  c_erase: cover property (flashStep && flashOp == CMD_BLOCK_ERASE);
endmodule
bind flash_self_program_mode_ctrl flash_mode_props u_props (.clk_sys, .reset, .cpuWr, .haltExec,
  .protectLimit, .selfProgMode, .cpuHold, .flashAddrHi, .flashOp, .flashStep);
`default_nettype wire

// ==== testbench/flash_self_program_mode_ctrl_tb.sv ====
// testbench: protected mode sequences and flash commands with random operands
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_mode_ctrl_tb
  import flash_selfprog_pkg::*;
;
  localparam logic [4:0] LIM = 5'h08; // blocks below are protected
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  cpu_wr_t     cpuWr = '0;
  logic [7:0]  rdAddr = 8'h00;
  logic        haltExec = 1'b0;
  logic [4:0]  protectLimit = LIM;
  logic        cellFail = 1'b0;
  logic [7:0]  rdData, flashAddrHi, flashAddrLo, flashWrData;
  logic [2:0]  flashOp;
  logic        selfProgMode, cpuHold, flashStep;
  int          stepCnt = 0;
  int          err_total = 0;
  int          num_checks = 0;
  logic [15:0] lfsr = 16'hA483; // seed 42115
  // clock
  always #2.5 clk_sys = ~clk_sys;
  flash_self_program_mode_ctrl u_dut (.clk_sys, .reset, .cpuWr, .rdAddr, .haltExec, .protectLimit,
    .cellFail, .rdData, .selfProgMode, .cpuHold, .flashAddrHi, .flashAddrLo, .flashWrData,
    .flashOp, .flashStep);
  // count array steps issued by the block
  always @(posedge clk_sys) begin
    if (flashStep === 1'b1) begin
      stepCnt <= stepCnt + 1;
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected status after a command
  function automatic logic [7:0] expst(logic [2:0] c, logic [7:0] hi, logic f);
    if (c == 3'h0) return 8'h00;
    if (c > CMD_BYTE_WRITE) return 8'h06;
    if (hi[4:0] < protectLimit) return 8'h04;
    if (f) return (c == CMD_BYTE_WRITE) ? 8'h04 : 8'h02;
    return 8'h00;
  endfunction
  // expected number of array steps; verify and blank check walk low pointer 00H to 02H
  function automatic logic [7:0] expstep(logic [2:0] c, logic [7:0] hi, logic f);
    if (c == 3'h0 || c > CMD_BYTE_WRITE || hi[4:0] < protectLimit) return 8'h00;
    if (f || c == CMD_BLOCK_ERASE || c == CMD_BYTE_WRITE) return 8'h01;
    return 8'h03;
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    cpuWr = '{1'b1, a, d};
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(negedge clk_sys);
      cpuWr.wrEn = 1'b0;
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    idle(1);
    rdAddr = a;
    idle(1);
    chk(rdData, e);
  endtask
  // clear command and status ahead of a sequence
  task automatic prep();
    wr(ADDR_FLASH_CMD, 8'h00);
    wr(ADDR_STATUS, 8'h00);
  endtask
  task automatic seq(logic [7:0] v, logic old);
    prep();
    wr(ADDR_PROTECT_CMD, PROTECT_KEY);
    wr(ADDR_MODE_CTRL, v);
    wr(ADDR_MODE_CTRL, ~v);
    chk(8'(selfProgMode), 8'(old));
    wr(ADDR_MODE_CTRL, v);
    chk(8'(selfProgMode), 8'(old));
    idle(1);
    chk(8'(selfProgMode), 8'(v[0]));
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_MODE_CTRL, {7'h00, v[0]});
  endtask
  task automatic cmd(logic [2:0] c, logic [7:0] hi, logic f);
    int s0;
    wr(ADDR_FLASH_CMD, {5'h00, c});
    wr(ADDR_PTR_HIGH, hi);
    wr(ADDR_PTR_LOW, 8'h00);
    wr(ADDR_CMP_HIGH, hi);
    wr(ADDR_CMP_LOW, 8'h02);
    wr(ADDR_WRITE_BUF, ~hi);
    wr(ADDR_STATUS, 8'h00);
    idle(1);
    s0 = stepCnt;
    {haltExec, cellFail} = {1'b1, f};
    idle(1);
    haltExec = 1'b0;
    chk(8'(cpuHold), 8'(c != 3'h0));
    chk(8'(flashOp), 8'(c));
    repeat (9000) if (cpuHold === 1'b1) idle(1);
    chk(8'(cpuHold), 8'h00);
    chk(8'(stepCnt - s0), expstep(c, hi, f));
    chk(flashAddrLo, (expstep(c, hi, f) == 8'h03) ? 8'h02 : 8'h00);
    chk(flashAddrHi, hi);
    chk(flashWrData, ~hi);
    rd(ADDR_STATUS, expst(c, hi, f));
    rd(ADDR_FLASH_CMD, {5'h00, c});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    chk(8'(selfProgMode), 8'h00);
    prep();
    wr(ADDR_PROTECT_CMD, PROTECT_KEY);
    wr(ADDR_MODE_CTRL, MODE_SELF);
    wr(ADDR_MODE_CTRL, 8'hFF);
    wr(ADDR_MODE_CTRL, MODE_SELF);
    rd(ADDR_STATUS, 8'h01);
    chk(8'(selfProgMode), 8'h00);
    prep();
    wr(ADDR_MODE_CTRL, MODE_SELF);
    rd(ADDR_STATUS, 8'h01);
    seq(MODE_SELF, 1'b0);
    cmd(3'h0, 8'h10, 1'b0);
    for (int i = 1; i < 8; i++) cmd(3'(i), 8'h0C, 1'b0);
    cmd(CMD_BLOCK_ERASE, 8'h03, 1'b0);
    cmd(CMD_BLOCK_ERASE, 8'h1F, 1'b1);
    cmd(CMD_BLOCK_ERASE, 8'h1F, 1'b0);
    protectLimit = 5'h00;
    cmd(CMD_BLOCK_ERASE, 8'h00, 1'b0);
    repeat (8) begin
      lfsr = nxt(lfsr);
      protectLimit = lfsr[14:10];
      cmd(lfsr[2:0] == 3'h0 ? CMD_BLOCK_ERASE : lfsr[2:0], {3'h0, lfsr[8:4]}, lfsr[9]);
    end
    seq(MODE_NORMAL, 1'b1);
    wrap_up();
  end
  // watchdog
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
